// ==== dpt_pkg.sv ====
// Constants, types and helpers shared by both link ends
// Contract
// RULE1 - Header byte: two-bit channel, six-bit type
// RULE2 - Read request: type 06h, code, zero
// RULE3 - After turnaround answer error report or data
// RULE4 - Null filler long packet: payload discarded
// RULE5 - Trailer: type 08h, 0Fh, 0Fh, 01h
// RULE6 - Bursts accepted with or without trailer
// RULE7 - Missing high-speed trailer flags protocol error; the device flags it only once a valid trailer has been seen since reset
// RULE8 - Device never sends a trailer
// RULE9 - Device answers in low power only
// RULE10 - Sync types 01h, 11h, 21h, 31h
// RULE11 - Vertical sync start/end imply line start
// RULE12 - Host may send lone or paired syncs
// RULE13 - Type 12h selects eight-colour mode
// RULE14 - Type 02h returns to full colour
// RULE15 - Type 22h blanks display, receiver stays on
// RULE16 - Type 32h turns the display on
// RULE17 - Blanking long packet 19h: payload unused
// RULE18 - Long packet: header, count, payload, checksum
// RULE19 - Host sends about one line per burst
// RULE20 - Host sets return size before reads
// RULE21 - Error report is type 02h, bit per error
// RULE22 - Four header bytes; long type checked first
package dpt_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int HALF_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam logic [2:0] HALF_MAX = 3'(HALF_CYC - 1);
  localparam logic [5:0] DT_VS_START = 6'h01;
  localparam logic [5:0] DT_VS_END = 6'h11;
  localparam logic [5:0] DT_HS_START = 6'h21;
  localparam logic [5:0] DT_HS_END = 6'h31;
  localparam logic [5:0] DT_COLOUR_ON = 6'h12;
  localparam logic [5:0] DT_COLOUR_OFF = 6'h02;
  localparam logic [5:0] DT_SHUTDOWN = 6'h22;
  localparam logic [5:0] DT_TURN_ON = 6'h32;
  localparam logic [5:0] DT_READ_REQ = 6'h06;
  localparam logic [5:0] DT_TRAILER = 6'h08;
  localparam logic [5:0] DT_MAX_RET = 6'h37;
  localparam logic [5:0] DT_WRITE0 = 6'h05;
  localparam logic [5:0] DT_WRITE1 = 6'h15;
  localparam logic [5:0] DT_NULL = 6'h09;
  localparam logic [5:0] DT_BLANK = 6'h19;
  localparam logic [5:0] DT_ACK_ERR = 6'h02;
  localparam logic [5:0] DT_RD_RESP1 = 6'h21;
  localparam logic [1:0] VC_HOST = 2'h0;
  localparam logic [7:0] TRAILER_DATA = 8'h0F;
  localparam logic [7:0] TRAILER_ECC = 8'h01;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int ERR_DT_BIT = 11;
  localparam int ERR_VC_BIT = 12;
  localparam int ERR_PROTO_BIT = 15;
  localparam logic [16:0] CRC_BYTES = 17'h00002;
  localparam logic [16:0] LAST_LEFT = 17'h00001;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [0:0] {P_HDR = 1'b0, P_PAY = 1'b1} dpt_parse_t;
  typedef enum logic [0:0] {T_IDLE = 1'b0, T_SEND = 1'b1} dpt_tx_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEND = 2'b01, H_TRAIL = 2'b10, H_GAP = 2'b11} dpt_host_t;

  // Long packets have bit 3 set and a nonzero low field
  function automatic logic is_long(input logic [5:0] dt);
    return dt[3] && (dt[2:0] != 3'h0);
  endfunction

  // Header byte on the host channel
  function automatic logic [7:0] make_di(input logic [5:0] dt);
    return {VC_HOST, dt}; // RULE1
  endfunction

  // Level changes only once second and third stages agree
  function automatic logic filt(input logic a, input logic b, input logic q);
    return (a == b) ? a : q;
  endfunction
endpackage

// ==== dpt_link_if.sv ====
// Link wires between host end and device end
`timescale 1ns/1ps
interface dpt_link_if;
  logic       host_clk;
  logic       host_frame;
  logic       host_hs;
  logic [7:0] host_data;
  logic       dev_clk;
  logic       dev_frame;
  logic [7:0] dev_data;
  modport host (output host_clk, host_frame, host_hs, host_data, input dev_clk, dev_frame, dev_data);
  modport dev (input host_clk, host_frame, host_hs, host_data, output dev_clk, dev_frame, dev_data);
endinterface // dpt_link_if

// ==== dpt_fifo.sv ====
// Flop-based FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dpt_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  wire logic     push = in_valid && in_ready;
  wire logic     pop  = out_valid && out_ready;

  // Occupancy after this cycle
  assign next_cnt = (AW+1)'(cnt + (AW+1)'(push) - (AW+1)'(pop));
  assign out_data = mem[rp];

  // Pointers and registered flags
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= (wp == LAST_IDX) ? '0 : AW'(wp + 1'b1);
      end
      if (pop) begin
        rp <= (rp == LAST_IDX) ? '0 : AW'(rp + 1'b1);
      end
      cnt <= next_cnt;
      in_ready <= next_cnt != FULL_CNT;
      out_valid <= next_cnt != '0;
    end
  end

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule // dpt_fifo

// ==== dpt_host.sv ====
// Host end: buffered byte sender with optional trailer, answer receiver
`timescale 1ns/1ps
module dpt_host
  import dpt_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Link to the device
  dpt_link_if.host        link,
  // Bytes to send
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // Burst options
  input  wire logic       hs_mode,
  input  wire logic       trailer_en,
  // Answer bytes
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic               fo_valid;
  logic [FIFO_W-1:0]  fo_data;
  logic               pop;
  dpt_host_t          st;
  logic [2:0]         div;
  logic               last_q;
  logic               trl;
  logic [1:0]         tidx;
  logic [2:0]         clk_s;
  logic [2:0]         frm_s;
  logic [2:0][7:0]    dat_s;
  logic               clk_q;
  logic               frm_q;
  wire logic          tick = div == HALF_MAX;
  wire logic          stall = (st == H_SEND) && !last_q && !fo_valid;
  wire logic          fall_go = tick && link.host_clk && !stall;
  wire logic          rise_go = tick && !link.host_clk;
  wire logic          next_clk = filt(clk_s[1], clk_s[2], clk_q);
  wire logic          next_frm = filt(frm_s[1], frm_s[2], frm_q);

  // Pop at the falling edge whenever a frame byte is due
  assign pop = fall_go && fo_valid && (st == H_IDLE || (st == H_SEND && !last_q));

  dpt_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) dpt_fifo_i (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (tx_valid),
    .in_data   ({tx_last, tx_data}),
    .in_ready  (tx_ready),
    .out_valid (fo_valid),
    .out_data  (fo_data),
    .out_ready (pop)
  );

  // Link clock divider; clock held high while the buffer runs dry
  always_ff @(posedge clock) begin
    if (!resetn) begin
      div <= '0;
      link.host_clk <= 1'b0;
    end else begin
      div <= (rise_go || fall_go) ? '0 : (tick ? div : 3'(div + 1'b1));
      if (rise_go || fall_go) begin
        link.host_clk <= !link.host_clk;
      end
    end
  end

  // Frame sequencer, data changes on falling link edges
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= H_IDLE;
      link.host_frame <= 1'b0;
      link.host_hs <= 1'b0;
      link.host_data <= ZERO_BYTE;
      last_q <= 1'b0;
      trl <= 1'b0;
      tidx <= '0;
    end else if (fall_go) begin
      case (st)
        H_IDLE: begin
          if (fo_valid) begin
            st <= H_SEND;
            link.host_frame <= 1'b1;
            link.host_hs <= hs_mode;
            trl <= trailer_en;
            link.host_data <= fo_data[7:0];
            last_q <= fo_data[8];
          end
        end
        H_SEND: begin
          if (!last_q) begin
            link.host_data <= fo_data[7:0];
            last_q <= fo_data[8];
          end else if (trl) begin
            st <= H_TRAIL;
            link.host_data <= make_di(DT_TRAILER); // RULE5
            tidx <= 2'h1;
          end else begin
            st <= H_GAP;
            link.host_frame <= 1'b0;
          end
        end
        H_TRAIL: begin
          if (tidx == '0) begin
            st <= H_GAP;
            link.host_frame <= 1'b0;
          end else begin
            link.host_data <= (tidx == HDR_LAST) ? TRAILER_ECC : TRAILER_DATA; // RULE5
            tidx <= 2'(tidx + 1'b1);
          end
        end
        H_GAP: begin
          st <= H_IDLE;
          link.host_hs <= 1'b0;
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // Answer receiver: three-stage sampling, byte taken on rising edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clk_s <= '0;
      frm_s <= '0;
      dat_s <= '0;
      clk_q <= 1'b0;
      frm_q <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= ZERO_BYTE;
    end else begin
      clk_s <= {clk_s[1:0], link.dev_clk};
      frm_s <= {frm_s[1:0], link.dev_frame};
      dat_s <= {dat_s[1:0], link.dev_data};
      clk_q <= next_clk;
      frm_q <= next_frm;
      rx_valid <= next_clk && !clk_q && frm_q;
      if (next_clk && !clk_q && frm_q) begin
        rx_data <= dat_s[2];
      end
    end
  end
endmodule // dpt_host

// ==== dpt_device.sv ====
// Device end: packet type decoder with low-power answer path
`timescale 1ns/1ps
module dpt_device
  import dpt_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // Link to the host
  dpt_link_if.dev         link,
  // Options and read answer
  input  wire logic       missing_trailer_error_disable,
  input  wire logic [7:0] read_data,
  // Sync events
  output logic            vs_start,
  output logic            vs_end,
  output logic            hs_start,
  output logic            hs_end,
  // Display state
  output logic            eight_colour,
  output logic            display_on,
  // Read request and errors
  output logic            read_req,
  output logic [7:0]      read_cmd,
  output logic            protocol_error
);
  logic [2:0]      clk_s;
  logic [2:0]      frm_s;
  logic [2:0]      hs_s;
  logic [2:0][7:0] dat_s;
  logic            clk_q;
  logic            frm_q;
  logic            hs_q;
  dpt_parse_t      st;
  logic [1:0]      idx;
  logic [7:0]      di;
  logic [7:0]      d0;
  logic [7:0]      d1;
  logic [16:0]     left;
  logic            burst_hs;
  logic            seen_trailer;
  logic            trailer_used;
  logic            pend_read;
  logic [15:0]     err;
  dpt_tx_t         tst;
  logic [2:0]      div;
  logic [1:0]      tidx;
  logic [31:0]     shift;
  logic            tx_go;

  // Filtered link levels and their edges
  wire logic       next_clk = filt(clk_s[1], clk_s[2], clk_q);
  wire logic       next_frm = filt(frm_s[1], frm_s[2], frm_q);
  wire logic       next_hs = filt(hs_s[1], hs_s[2], hs_q);
  wire logic       take = next_clk && !clk_q && frm_q;
  wire logic       frame_rise = next_frm && !frm_q;
  wire logic       frame_fall = !next_frm && frm_q;
  wire logic [7:0] byte_in = dat_s[2];

  // Header decode at the fourth byte
  wire logic [5:0] dt = di[5:0];
  wire logic       vc_ok = di[7:6] == VC_HOST; // RULE1
  wire logic       hdr_end = take && (st == P_HDR) && (idx == HDR_LAST); // RULE22
  wire logic       short_end = hdr_end && !is_long(dt); // RULE22
  wire logic       trailer_ok = (d0 == TRAILER_DATA) && (d1 == TRAILER_DATA) && (byte_in == TRAILER_ECC); // RULE5
  wire logic       known = (dt == DT_VS_START) || (dt == DT_VS_END) || (dt == DT_HS_START)
                        || (dt == DT_HS_END) || (dt == DT_COLOUR_ON) || (dt == DT_COLOUR_OFF)
                        || (dt == DT_SHUTDOWN) || (dt == DT_TURN_ON) || (dt == DT_READ_REQ)
                        || (dt == DT_TRAILER) || (dt == DT_MAX_RET) || (dt == DT_WRITE0)
                        || (dt == DT_WRITE1);

  // Short packet of a given type on the host channel
  function automatic logic is_dt(input logic [5:0] x);
    return short_end && vc_ok && (dt == x);
  endfunction

  // Trailer checks and error collection
  wire logic       bad_trailer = is_dt(DT_TRAILER) && !trailer_ok;
  wire logic       missing = frame_fall && burst_hs && trailer_used && !seen_trailer
                          && !missing_trailer_error_disable; // RULE7
  wire logic       send_start = frame_fall && pend_read;
  wire logic [15:0] err_set = (16'(hdr_end && !vc_ok) << ERR_VC_BIT)
                           | (16'(short_end && vc_ok && !known) << ERR_DT_BIT)
                           | (16'(missing || bad_trailer) << ERR_PROTO_BIT);
  wire logic [15:0] err_clr = send_start ? err : '0;

  // Answer: error report if anything was flagged, else the read data
  wire logic [31:0] resp = (err != '0)
                        ? {ZERO_BYTE, err[15:8], err[7:0], make_di(DT_ACK_ERR)} // RULE21
                        : {ZERO_BYTE, ZERO_BYTE, read_data, make_di(DT_RD_RESP1)}; // RULE3
  wire logic        tick = div == HALF_MAX;
  wire logic        fall_tick = tick && link.dev_clk;

  // Three-stage sampling of every link input
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clk_s <= '0;
      frm_s <= '0;
      hs_s <= '0;
      dat_s <= '0;
      clk_q <= 1'b0;
      frm_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      clk_s <= {clk_s[1:0], link.host_clk};
      frm_s <= {frm_s[1:0], link.host_frame};
      hs_s <= {hs_s[1:0], link.host_hs};
      dat_s <= {dat_s[1:0], link.host_data};
      clk_q <= next_clk;
      frm_q <= next_frm;
      hs_q <= next_hs;
    end
  end

  // Packet walker: header bytes, then payload and checksum skipped
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st <= P_HDR;
      idx <= '0;
      di <= ZERO_BYTE;
      d0 <= ZERO_BYTE;
      d1 <= ZERO_BYTE;
      left <= '0;
    end else if (frame_rise || frame_fall) begin
      st <= P_HDR;
      idx <= '0;
    end else if (take) begin
      case (st)
        P_HDR: begin
          case (idx)
            2'h0: di <= byte_in;
            2'h1: d0 <= byte_in;
            2'h2: d1 <= byte_in;
            default: ;
          endcase
          idx <= 2'(idx + 1'b1);
          if (hdr_end && is_long(dt)) begin
            st <= P_PAY; // RULE4 RULE17
            left <= 17'({1'b0, d1, d0} + CRC_BYTES); // RULE18
          end
        end
        P_PAY: begin
          left <= 17'(left - LAST_LEFT); // RULE4 RULE17
          if (left == LAST_LEFT) begin
            st <= P_HDR;
          end
        end
        default: st <= P_HDR;
      endcase
    end
  end

  // Event pulses and display mode state
  always_ff @(posedge clock) begin
    if (!resetn) begin
      vs_start <= 1'b0;
      vs_end <= 1'b0;
      hs_start <= 1'b0;
      hs_end <= 1'b0;
      eight_colour <= 1'b0;
      display_on <= 1'b1;
      read_req <= 1'b0;
      read_cmd <= ZERO_BYTE;
    end else begin
      vs_start <= is_dt(DT_VS_START); // RULE10 RULE12
      vs_end <= is_dt(DT_VS_END); // RULE10
      hs_start <= is_dt(DT_HS_START) || is_dt(DT_VS_START) || is_dt(DT_VS_END); // RULE10 RULE11
      hs_end <= is_dt(DT_HS_END); // RULE10
      if (is_dt(DT_COLOUR_ON)) begin
        eight_colour <= 1'b1; // RULE13
      end else if (is_dt(DT_COLOUR_OFF)) begin
        eight_colour <= 1'b0; // RULE14
      end
      if (is_dt(DT_SHUTDOWN)) begin
        display_on <= 1'b0; // RULE15
      end else if (is_dt(DT_TURN_ON)) begin
        display_on <= 1'b1; // RULE16
      end
      read_req <= is_dt(DT_READ_REQ);
      if (is_dt(DT_READ_REQ)) begin
        read_cmd <= d0; // RULE2
      end
    end
  end

  // Trailer tracking per burst, pending read and sticky errors
  always_ff @(posedge clock) begin
    if (!resetn) begin
      burst_hs <= 1'b0;
      seen_trailer <= 1'b0;
      trailer_used <= 1'b0;
      pend_read <= 1'b0;
      err <= '0;
      protocol_error <= 1'b0;
    end else begin
      if (frame_rise) begin
        burst_hs <= next_hs;
        seen_trailer <= 1'b0; // RULE6
      end else if (is_dt(DT_TRAILER) && trailer_ok) begin
        seen_trailer <= 1'b1;
        trailer_used <= 1'b1; // RULE7
      end
      if (is_dt(DT_READ_REQ)) begin
        pend_read <= 1'b1;
      end else if (frame_fall) begin
        pend_read <= 1'b0;
      end
      err <= (err & ~err_clr) | err_set; // RULE21
      protocol_error <= missing; // RULE7
    end
  end

  // Answer sender: own divided clock, four bytes, low power, no trailer
  always_ff @(posedge clock) begin
    if (!resetn) begin
      div <= '0;
      link.dev_clk <= 1'b0;
      link.dev_frame <= 1'b0;
      link.dev_data <= ZERO_BYTE;
      tst <= T_IDLE;
      tidx <= '0;
      shift <= '0;
      tx_go <= 1'b0;
    end else begin
      div <= tick ? '0 : 3'(div + 1'b1);
      if (tick) begin
        link.dev_clk <= !link.dev_clk;
      end
      if (fall_tick) begin
        case (tst)
          T_IDLE: begin
            if (tx_go) begin
              tst <= T_SEND; // RULE9
              tx_go <= 1'b0;
              link.dev_frame <= 1'b1;
              link.dev_data <= shift[7:0];
              shift <= {ZERO_BYTE, shift[31:8]};
              tidx <= '0;
            end
          end
          T_SEND: begin
            if (tidx == HDR_LAST) begin
              tst <= T_IDLE; // RULE8
              link.dev_frame <= 1'b0;
            end else begin
              link.dev_data <= shift[7:0];
              shift <= {ZERO_BYTE, shift[31:8]};
              tidx <= 2'(tidx + 1'b1);
            end
          end
          default: tst <= T_IDLE;
        endcase
      end
      if (send_start) begin
        shift <= resp; // RULE3
        tx_go <= 1'b1;
      end
    end
  end
endmodule // dpt_device

// ==== dpt_chk.sv ====
// Checker of the link wires between the host end and the device end
`timescale 1ns/1ps
module dpt_chk
  import dpt_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Host side wires
  input wire logic       host_clk,
  input wire logic       host_frame,
  input wire logic       host_hs,
  input wire logic [7:0] host_data,
  // Device side wires
  input wire logic       dev_clk,
  input wire logic       dev_frame,
  input wire logic [7:0] dev_data
);
  logic       dclk_q;
  logic [2:0] ans_cnt;
  wire        drise = dev_clk && !dclk_q;

  // Count answer bytes at answer clock rises
  always_ff @(posedge clock) begin
    dclk_q <= dev_clk;
    if (!resetn || !dev_frame) ans_cnt <= 3'h0;
    else if (drise) ans_cnt <= ans_cnt + 3'h1;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Host byte lanes and framing
  data_stable_a: assert property (host_clk && $past(host_clk) |-> $stable(host_data))
    else $error("host byte changed while link clock high");
  hs_steady_a: assert property (host_frame && $past(host_frame) |-> $stable(host_hs))
    else $error("burst mode changed inside a frame");
  frame_start_a: assert property ($rose(host_frame) |-> !host_clk)
    else $error("frame opened away from a clock fall");
  link_half_a: assert property ($rose(host_clk) |-> host_clk [*4])
    else $error("link clock high phase too short");
  // Answer packets from the device
  answer_type_a: assert property (drise && dev_frame && ans_cnt == 3'h0 |->
    dev_data == {VC_HOST, DT_ACK_ERR} || dev_data == {VC_HOST, DT_RD_RESP1})
    else $error("answer header is neither error report nor read data");
  answer_ecc_a: assert property (drise && dev_frame && ans_cnt == 3'h3 |-> dev_data == 8'h00)
    else $error("answer last byte not zero");
  answer_len_a: assert property ($fell(dev_frame) |-> ans_cnt == 3'h4)
    else $error("answer not four bytes long");
  turnaround_a: assert property (dev_frame |-> !host_frame)
    else $error("device answered while host frame open");
  answer_edge_a: assert property ($rose(dev_frame) |-> !dev_clk)
    else $error("answer frame opened away from a clock fall");

  // Main scenarios seen
  hs_burst_c: cover property ($rose(host_frame) && host_hs);
  err_answer_c: cover property (drise && dev_frame && dev_data == {VC_HOST, DT_ACK_ERR});
  answer_end_c: cover property ($fell(dev_frame));
endmodule // dpt_chk

// ==== dsi_packet_type_decoder_tb.sv ====
// Bench joining host and device ends with event and answer scoreboards
`timescale 1ns/1ps
module dsi_packet_type_decoder_tb
  import dpt_pkg::*;
;
  localparam logic [5:0] DTS [8] = '{6'h01, 6'h11, 6'h21, 6'h31, 6'h12, 6'h22, 6'h32, 6'h02};
  localparam logic [3:0] EVS [8] = '{4'hA, 4'h6, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0};
  logic        clock      = 1'b0;
  logic        resetn     = 1'b0;
  logic        tx_valid   = 1'b0;
  logic [7:0]  tx_data    = 8'h00;
  logic        tx_last    = 1'b0;
  logic        hs_mode    = 1'b0;
  logic        trailer_en = 1'b0;
  logic        trail_dis  = 1'b0;
  logic [7:0]  read_data  = 8'h00;
  logic [7:0]  rd;
  logic [31:0] rng        = 32'h00000058;
  logic        tx_ready, rx_valid, vs_start, vs_end, hs_start, hs_end;
  logic        eight_colour, display_on, read_req, protocol_error;
  logic [7:0]  rx_data, read_cmd;
  logic [13:0] ev_q[$];
  logic [7:0]  rx_q[$];
  logic [7:0]  fr[$];
  int          failures   = 0;
  int          n_compared = 0;
  wire  [13:0] ev_seen = {vs_start, vs_end, hs_start, hs_end, read_req, protocol_error, read_req ? read_cmd : 8'h00};

  // Both ends face each other across the link
  dpt_link_if link ();
  dpt_host dpt_host_i (.clock(clock), .resetn(resetn), .link(link), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .hs_mode(hs_mode), .trailer_en(trailer_en), .rx_valid(rx_valid),
    .rx_data(rx_data));
  dpt_device dpt_device_i (.clock(clock), .resetn(resetn), .link(link), .missing_trailer_error_disable(trail_dis),
    .read_data(read_data), .vs_start(vs_start), .vs_end(vs_end), .hs_start(hs_start), .hs_end(hs_end),
    .eight_colour(eight_colour), .display_on(display_on), .read_req(read_req), .read_cmd(read_cmd),
    .protocol_error(protocol_error));
  dpt_chk dpt_chk_i (.clock(clock), .resetn(resetn), .host_clk(link.host_clk), .host_frame(link.host_frame),
    .host_hs(link.host_hs), .host_data(link.host_data), .dev_clk(link.dev_clk), .dev_frame(link.dev_frame),
    .dev_data(link.dev_data));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Xorshift source for payload and data bytes
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic pk(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
    fr = {fr, a, b, c, d};
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      check("wait bound", 16'h0001, 16'h0000);
      finish_test();
    end
  endtask

  // Push the frame bytes through the buffer, then wait for the frame to close
  task automatic send(input logic hs, input logic tr);
    int k;
    hs_mode <= hs;
    trailer_en <= tr;
    for (int i = 0; i < fr.size(); i++) begin
      tx_valid <= 1'b1;
      tx_data <= fr[i];
      tx_last <= (i == fr.size() - 1);
      k = 0;
      @(posedge clock);
      while (tx_ready !== 1'b1 && k < 200) begin
        k++;
        @(posedge clock);
      end
      bound(k, 200);
    end
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    fr = {};
    for (k = 0; k < 400 && link.host_frame !== 1'b1; k++) @(posedge clock);
    bound(k, 400);
    for (k = 0; k < 4000 && link.host_frame !== 1'b0; k++) @(posedge clock);
    bound(k, 4000);
    repeat (24) @(posedge clock);
  endtask

  task automatic wait_rx();
    int k;
    for (k = 0; k < 600 && rx_q.size() != 0; k++) @(posedge clock);
    bound(k, 600);
    repeat (16) @(posedge clock);
  endtask

  // Scoreboard: oldest note against each pulse or answer byte
  always @(negedge clock) begin
    if (resetn === 1'b1 && ev_seen[13:8] !== 6'h00)
      check("event", ev_seen, ev_q.size() ? ev_q.pop_front() : 14'h0000);
    if (rx_valid === 1'b1)
      check("answer byte", rx_data, rx_q.size() ? rx_q.pop_front() : 8'h00);
  end

  initial begin
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    // Each sync and command type alone in a low-power frame
    for (int i = 0; i < 8; i++) begin
      pk({2'h0, DTS[i]}, rnd(), rnd(), rnd());
      if (EVS[i] != 4'h0) ev_q.push_back({EVS[i], 10'h000});
      send(1'b0, 1'b0);
      check("eight_colour", eight_colour, i >= 4 && i < 7);
      check("display_on", display_on, i != 5);
    end
    // Bad channel and unknown type, then a read in the same frame
    pk(8'h61, 8'h00, 8'h00, rnd());
    pk(8'h03, 8'h00, 8'h00, rnd());
    pk(8'h37, 8'h01, 8'h00, rnd());
    pk(8'h06, 8'hDA, 8'h00, rnd());
    ev_q.push_back({6'h02, 8'hDA});
    rx_q = {8'h02, 8'h00, 8'h18, 8'h00};
    send(1'b0, 1'b0);
    wait_rx();
    // Burst with filler and blanking packets, closed by a trailer
    pk(8'h09, 8'h0C, 8'h00, rnd());
    repeat (14) fr.push_back(rnd());
    pk(8'h21, rnd(), rnd(), rnd());
    pk(8'h19, 8'h02, 8'h00, rnd());
    pk(8'h31, 8'h00, rnd(), rnd());
    pk(8'h11, rnd(), rnd(), rnd());
    ev_q.push_back({4'h2, 10'h000});
    ev_q.push_back({4'h6, 10'h000});
    send(1'b1, 1'b1);
    // Bursts missing the trailer, muted and then reported
    trail_dis <= 1'b1;
    pk(8'h21, rnd(), rnd(), rnd());
    ev_q.push_back({4'h2, 10'h000});
    send(1'b1, 1'b0);
    trail_dis <= 1'b0;
    pk(8'h21, rnd(), rnd(), rnd());
    ev_q.push_back({4'h2, 10'h000});
    ev_q.push_back({6'h01, 8'h00});
    send(1'b1, 1'b0);
    // Error report, then a clean read answer
    pk(8'h06, 8'hDA, 8'h00, rnd());
    ev_q.push_back({6'h02, 8'hDA});
    rx_q = {8'h02, 8'h00, 8'h80, 8'h00};
    send(1'b0, 1'b0);
    wait_rx();
    rd = rnd();
    read_data <= rd;
    pk(8'h06, 8'h0A, 8'h00, rnd());
    ev_q.push_back({6'h02, 8'h0A});
    rx_q = {8'h21, rd, 8'h00, 8'h00};
    send(1'b0, 1'b0);
    wait_rx();
    check("tx_ready", tx_ready, 16'h0001);
    check("notes left", 16'(ev_q.size() + rx_q.size()), 16'h0000);
    finish_test();
  end
endmodule // dsi_packet_type_decoder_tb
